// ==== logic/hamsc_debounce.sv ====
// debounce filter for one contact input
`timescale 1ns/1ps
`include "hamsc_map.svh"
module hamsc_debounce import hamsc_pkg::*; #(
	parameter int CYCLES = `HAMSC_DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// contact
	input wire logic raw_i,
	output logic clean_o
);
	localparam int CNT_W = $clog2(CYCLES + 1);

	logic [CNT_W-1:0] cnt, next_cnt;
	logic next_clean;

	// output follows only after the raw level held for the full settling time
	always_comb begin
		next_cnt = '0;
		next_clean = clean_o;
		if (raw_i != clean_o) begin
			if (cnt == CNT_W'(CYCLES - 1)) begin
				next_clean = raw_i;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnt <= '0;
			clean_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			clean_o <= next_clean;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// a bounce shorter than the settling time never reaches the output
	property p_db_settle;
		$changed(clean_o) |-> $past(raw_i) == clean_o && $past(cnt) == CNT_W'(CYCLES - 1);
	endproperty
	a_db_settle: assert property (p_db_settle) else $error("debounce output moved early");
endmodule : hamsc_debounce

// ==== logic/hamsc_fb_check.sv ====
// contactor feedback timer: flags missing feedback after the contactor closes
`timescale 1ns/1ps
`include "hamsc_map.svh"
module hamsc_fb_check import hamsc_pkg::*; #(
	parameter int LIMIT_CYCLES = `HAMSC_FB_LIMIT_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// link to the supervisor
	hamsc_fb_if.chk fb
);
	localparam int CNT_W = $clog2(LIMIT_CYCLES + 1);

	logic [CNT_W-1:0] cnt, next_cnt;
	logic seen, next_seen;
	logic next_missing;

	// count only while energised and feedback never yet seen this closure
	always_comb begin
		next_cnt = cnt;
		next_seen = seen;
		next_missing = 1'b0;
		if (!fb.energised) begin
			next_cnt = '0;
			next_seen = 1'b0;
		end else if (fb.feedback || seen) begin
			next_seen = 1'b1;
		end else if (cnt == CNT_W'(LIMIT_CYCLES - 1)) begin
			next_missing = 1'b1;
			next_cnt = cnt + CNT_W'(1);
		end else if (cnt < CNT_W'(LIMIT_CYCLES - 1)) begin
			next_cnt = cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnt <= '0;
			seen <= 1'b0;
			fb.missing <= 1'b0;
		end else begin
			cnt <= next_cnt;
			seen <= next_seen;
			fb.missing <= next_missing;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// once feedback arrived during a closure no alarm may follow
	property p_fb_quiet;
		seen |-> !fb.missing;
	endproperty
	a_fb_quiet: assert property (p_fb_quiet) else $error("alarm after feedback seen");

	// alarm only at the full limit of an unanswered closure
	property p_fb_timed;
		fb.missing |-> $past(cnt) == CNT_W'(LIMIT_CYCLES - 1) && $past(fb.energised);
	endproperty
	a_fb_timed: assert property (p_fb_timed) else $error("alarm at wrong time");
endmodule : hamsc_fb_check

// ==== logic/hamsc_supervisor.sv ====
// hand/off/auto motor start supervisor driving the contactor A output
`timescale 1ns/1ps
`include "hamsc_map.svh"
module hamsc_supervisor import hamsc_pkg::*; #(
	parameter int IL_COUNT = `HAMSC_IL_COUNT,
	parameter int DEBOUNCE_CYCLES = `HAMSC_DEBOUNCE_CYC,
	parameter int FB_LIMIT_CYCLES = `HAMSC_FB_LIMIT_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// selector switch, high while in that position
	input wire logic sel_hand_i,
	input wire logic sel_auto_i,
	// field contacts, high when closed or pressed
	input wire logic stop_input_closed_i,
	input wire logic local_start_pb_i,
	input wire logic local_stop_pb_i,
	input wire logic maint_start_i,
	input wire logic auto_pulse_start_contact_i,
	input wire logic auto_pulse_stop_contact_i,
	input wire logic [IL_COUNT-1:0] interlock_i,
	input wire logic contactor_a_fb_i,
	// faceplate keys and serial start request
	input wire logic fp_stop_key_i,
	input wire logic fp_reset_key_i,
	input wire logic fp_start_key_i,
	input wire logic serial_start_i,
	// interlock function settings, one field per interlock input
	input wire logic [IL_COUNT*`HAMSC_IL_FUNC_W-1:0] il_func_i,
	// status and contactor drive
	output logic contactor_a_o,
	output logic motor_unavailable_o,
	output logic trip_latched_o,
	output logic fb_missing_alarm_o
);
	localparam int DB_W = `HAMSC_DB_IL + IL_COUNT;

	logic [DB_W-1:0] raw, db, db_prev, next_db_prev, rise;
	hamsc_state_type state, next_state;
	logic ctrl_prev, next_ctrl_prev;
	logic next_contactor, next_unavailable, next_trip, next_alarm;
	logic two_wire_cfg, il_scheme, auto_en_lvl, auto_start_lvl;
	logic hand, auto_m, off, stop_in, ctrl_lvl, ctrl_fall, rst_rise;
	logic stop_now, trip_set, start_req, restart_ok;

	hamsc_fb_if fb_if ();

	// every contact passes the same settling filter
	assign raw = {interlock_i, fp_start_key_i, fp_reset_key_i, fp_stop_key_i,
		contactor_a_fb_i, auto_pulse_stop_contact_i, auto_pulse_start_contact_i,
		maint_start_i, local_stop_pb_i, local_start_pb_i, stop_input_closed_i,
		sel_auto_i, sel_hand_i};

	for (genvar g = 0; g < DB_W; g++) begin : g_db
		hamsc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db (
			.sys_clk_i(sys_clk_i),
			.reset_i(reset_i),
			.raw_i(raw[g]),
			.clean_o(db[g])
		);
	end

	// feedback timer watches the registered contactor drive
	assign fb_if.energised = contactor_a_o;
	assign fb_if.feedback = db[`HAMSC_DB_FB];

	hamsc_fb_check #(.LIMIT_CYCLES(FB_LIMIT_CYCLES)) u_fb (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.fb(fb_if.chk)
	);

	// scheme follows the interlock settings; all unused means the default scheme
	always_comb begin
		two_wire_cfg = 1'b0;
		il_scheme = 1'b0;
		auto_en_lvl = 1'b0;
		auto_start_lvl = 1'b0;
		for (int i = 0; i < IL_COUNT; i++) begin
			case (hamsc_il_func_type'(il_func_i[i*`HAMSC_IL_FUNC_W +: `HAMSC_IL_FUNC_W]))
				HAMSC_IL_MAINT_RUN: begin
					two_wire_cfg = 1'b1;
				end
				HAMSC_IL_AUTO_ENABLE: begin
					il_scheme = 1'b1;
					auto_en_lvl = auto_en_lvl | db[`HAMSC_DB_IL + i];
				end
				HAMSC_IL_AUTO_START_A: begin
					auto_start_lvl = auto_start_lvl | db[`HAMSC_DB_IL + i];
				end
				default: begin
				end
			endcase
		end
	end

	// selector decode; in the interlock scheme the enable contact means auto
	always_comb begin
		rise = db & ~db_prev;
		auto_m = il_scheme ? auto_en_lvl : db[`HAMSC_DB_AUTO];
		hand = db[`HAMSC_DB_HAND] && !auto_m;
		off = !hand && !auto_m;
		stop_in = db[`HAMSC_DB_STOPIN];
		ctrl_lvl = db[`HAMSC_DB_MAINT] | auto_start_lvl;
		ctrl_fall = ctrl_prev && !ctrl_lvl;
		rst_rise = rise[`HAMSC_DB_FPRESET];
	end

	// stop, trip and start conditions per scheme and position
	always_comb begin
		stop_now = !stop_in || off;
		if (hand && rise[`HAMSC_DB_STOPPB]) begin
			stop_now = 1'b1;
		end
		if (auto_m && !il_scheme && two_wire_cfg && !db[`HAMSC_DB_MAINT]) begin
			stop_now = 1'b1;
		end
		if (auto_m && !il_scheme && !two_wire_cfg) begin
			if (!db[`HAMSC_DB_PSTOP] || rise[`HAMSC_DB_STOPPB]) begin
				stop_now = 1'b1;
			end
		end
		if (auto_m && il_scheme && (rise[`HAMSC_DB_STOPPB] || !ctrl_lvl)) begin
			stop_now = 1'b1;
		end
		trip_set = rise[`HAMSC_DB_FPSTOP] || fb_if.missing;
		if (il_scheme && hand && rise[`HAMSC_DB_STOPPB]) begin
			trip_set = 1'b1;
		end
		if (il_scheme && auto_m && ctrl_fall && state == HAMSC_ST_RUNNING) begin
			trip_set = 1'b1;
		end
		start_req = 1'b0;
		if (hand) begin
			start_req = rise[`HAMSC_DB_STARTPB] || rise[`HAMSC_DB_FPSTART] || serial_start_i;
		end else if (auto_m && il_scheme) begin
			start_req = ctrl_lvl;
		end else if (auto_m && two_wire_cfg) begin
			start_req = db[`HAMSC_DB_MAINT];
		end else if (auto_m) begin
			start_req = rise[`HAMSC_DB_PSTART];
		end
		restart_ok = (two_wire_cfg || il_scheme) && db[`HAMSC_DB_MAINT] && stop_in && !off;
	end

	// motor state; trip beats stop, stop beats start
	always_comb begin
		next_state = state;
		case (state)
			HAMSC_ST_STOPPED: begin
				if (trip_set) begin
					next_state = HAMSC_ST_TRIPPED;
				end else if (!stop_now && start_req) begin
					next_state = HAMSC_ST_RUNNING;
				end
			end
			HAMSC_ST_RUNNING: begin
				if (trip_set) begin
					next_state = HAMSC_ST_TRIPPED;
				end else if (stop_now) begin
					next_state = HAMSC_ST_STOPPED;
				end // holds after a momentary start lets go
			end
			HAMSC_ST_TRIPPED: begin
				if (rst_rise && !trip_set) begin
					next_state = restart_ok ? HAMSC_ST_RUNNING : HAMSC_ST_STOPPED;
				end // every start ignored while latched
			end
			default: begin
				next_state = HAMSC_ST_STOPPED;
			end
		endcase
		next_contactor = (next_state == HAMSC_ST_RUNNING);
		next_trip = (next_state == HAMSC_ST_TRIPPED);
		next_unavailable = !stop_in;
		next_alarm = fb_if.missing || (fb_missing_alarm_o && !rst_rise);
		next_db_prev = db;
		next_ctrl_prev = ctrl_lvl;
	end

	// one register set; outputs come straight from here
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= HAMSC_ST_STOPPED;
			contactor_a_o <= 1'b0;
			trip_latched_o <= 1'b0;
			motor_unavailable_o <= 1'b1;
			fb_missing_alarm_o <= 1'b0;
			db_prev <= '0;
			ctrl_prev <= 1'b0;
		end else begin
			state <= next_state;
			contactor_a_o <= next_contactor;
			trip_latched_o <= next_trip;
			motor_unavailable_o <= next_unavailable;
			fb_missing_alarm_o <= next_alarm;
			db_prev <= next_db_prev;
			ctrl_prev <= next_ctrl_prev;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_no_start_open;
		!stop_in && !contactor_a_o |=> !contactor_a_o;
	endproperty
	a_no_start_open: assert property (p_no_start_open) else $error("start with stop open");

	property p_unavail;
		!stop_in |=> motor_unavailable_o;
	endproperty
	a_unavail: assert property (p_unavail) else $error("unavailable not shown");

	sequence s_fb_missing;
		fb_if.missing ##1 fb_missing_alarm_o;
	endsequence
	property p_fb_drop;
		fb_if.missing |-> s_fb_missing ##0 (!contactor_a_o && trip_latched_o);
	endproperty
	a_fb_drop: assert property (p_fb_drop) else $error("contactor kept on missing feedback");

	sequence s_fp_trip;
		rise[`HAMSC_DB_FPSTOP] ##1 (trip_latched_o && !contactor_a_o);
	endsequence
	property p_fp_trip;
		rise[`HAMSC_DB_FPSTOP] |-> s_fp_trip;
	endproperty
	a_fp_trip: assert property (p_fp_trip) else $error("faceplate stop did not trip");

	property p_trip_hold;
		trip_latched_o && !rst_rise |=> !contactor_a_o && trip_latched_o;
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("start while trip latched");

	property p_restart;
		state == HAMSC_ST_TRIPPED && rst_rise && !trip_set && restart_ok |=> contactor_a_o;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart from maintained start");

	property p_off;
		off |=> !contactor_a_o;
	endproperty
	a_off: assert property (p_off) else $error("motor on in off");

	property p_two_wire;
		auto_m && !il_scheme && two_wire_cfg && !db[`HAMSC_DB_MAINT] |=> !contactor_a_o;
	endproperty
	a_two_wire: assert property (p_two_wire) else $error("two-wire auto kept running");

	property p_pb_ignored;
		auto_m && !il_scheme && two_wire_cfg && state == HAMSC_ST_RUNNING && !stop_now
			&& !trip_set && rise[`HAMSC_DB_STOPPB] |=> contactor_a_o;
	endproperty
	a_pb_ignored: assert property (p_pb_ignored) else $error("local stop acted in auto");

	property p_three_wire_stop;
		auto_m && !il_scheme && !two_wire_cfg && rise[`HAMSC_DB_STOPPB] |=> !contactor_a_o;
	endproperty
	a_three_wire_stop: assert property (p_three_wire_stop) else $error("local stop ignored");

	property p_il_hand_trip;
		il_scheme && hand && rise[`HAMSC_DB_STOPPB] |=> trip_latched_o;
	endproperty
	a_il_hand_trip: assert property (p_il_hand_trip) else $error("hand stop did not trip");

	property p_il_block;
		il_scheme && auto_m && !ctrl_lvl && state == HAMSC_ST_STOPPED |=> !contactor_a_o;
	endproperty
	a_il_block: assert property (p_il_block) else $error("blocked start accepted");

	property p_pstart;
		auto_m && !il_scheme && !two_wire_cfg && state == HAMSC_ST_STOPPED
			&& rise[`HAMSC_DB_PSTART] && !stop_now && !trip_set |=> contactor_a_o;
	endproperty
	a_pstart: assert property (p_pstart) else $error("pulse start ignored");

	// a released momentary start must not drop a running motor
	property p_run_hold;
		state == HAMSC_ST_RUNNING && !stop_now && !trip_set |=> contactor_a_o;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("running motor dropped");

	property p_il_stop;
		il_scheme && auto_m && rise[`HAMSC_DB_STOPPB] |=> !contactor_a_o;
	endproperty
	a_il_stop: assert property (p_il_stop) else $error("auto stop ignored");

	property p_il_trip;
		il_scheme && auto_m && ctrl_fall && state == HAMSC_ST_RUNNING |=> trip_latched_o;
	endproperty
	a_il_trip: assert property (p_il_trip) else $error("no trip on opening");
endmodule : hamsc_supervisor

// ==== shared/hamsc_fb_if.sv ====
// contactor feedback check signals between the supervisor and its timer
`timescale 1ns/1ps
interface hamsc_fb_if;
	logic energised;
	logic feedback;
	logic missing;

	modport ctl (output energised, output feedback, input missing);
	modport chk (input energised, input feedback, output missing);
endinterface : hamsc_fb_if

// ==== shared/hamsc_map.svh ====
// timing constants, field layout and input positions of the motor start supervisor
`ifndef HAMSC_MAP_SVH
`define HAMSC_MAP_SVH

// clock rate of sys_clk_i
`define HAMSC_CLK_HZ 10000000
// contactor feedback limit after closing the contactor output, in ms
`define HAMSC_FB_LIMIT_MS 1000
`define HAMSC_FB_LIMIT_CYC ((`HAMSC_FB_LIMIT_MS) * (`HAMSC_CLK_HZ / 1000))
// contact debounce settling time, in us
`define HAMSC_DEBOUNCE_US 2000
`define HAMSC_DEBOUNCE_CYC ((`HAMSC_DEBOUNCE_US) * (`HAMSC_CLK_HZ / 1000000))

// interlock inputs and the width of each one's function setting
`define HAMSC_IL_COUNT 10
`define HAMSC_IL_FUNC_W 2

// positions in the debounced contact vector
`define HAMSC_DB_HAND 0
`define HAMSC_DB_AUTO 1
`define HAMSC_DB_STOPIN 2
`define HAMSC_DB_STARTPB 3
`define HAMSC_DB_STOPPB 4
`define HAMSC_DB_MAINT 5
`define HAMSC_DB_PSTART 6
`define HAMSC_DB_PSTOP 7
`define HAMSC_DB_FB 8
`define HAMSC_DB_FPSTOP 9
`define HAMSC_DB_FPRESET 10
`define HAMSC_DB_FPSTART 11
`define HAMSC_DB_IL 12

`endif

// ==== shared/hamsc_pkg.sv ====
// types of the motor start supervisor
package hamsc_pkg;

	// motor state, gray along stopped -> running -> tripped
	typedef enum logic [1:0] {
		HAMSC_ST_STOPPED = 2'h0,
		HAMSC_ST_RUNNING = 2'h1,
		HAMSC_ST_TRIPPED = 2'h3
	} hamsc_state_type;

	// function assigned to one interlock input
	typedef enum logic [1:0] {
		HAMSC_IL_NOT_USED = 2'h0,
		HAMSC_IL_MAINT_RUN = 2'h1,
		HAMSC_IL_AUTO_ENABLE = 2'h2,
		HAMSC_IL_AUTO_START_A = 2'h3
	} hamsc_il_func_type;

endpackage : hamsc_pkg

// ==== testbench/hamsc_contactor_model.sv ====
// contactor model returning its normally-open auxiliary contact
`timescale 1ns/1ps
module hamsc_contactor_model #(
	parameter int PICKUP_CYCLES = 2
) (
	// clock
	input wire logic sys_clk_i,
	// coil drive and fault injection
	input wire logic coil_i,
	input wire logic withhold_i,
	// auxiliary contact
	output logic aux_no_o
);
	int count = 0;
	initial aux_no_o = 1'b0;
	// armature pulls in after a few cycles; withholding models a broken control circuit
	always @(posedge sys_clk_i) begin
		if (!coil_i || withhold_i) begin
			count <= 0;
			aux_no_o <= 1'b0;
		end else if (count < PICKUP_CYCLES) begin
			count <= count + 1;
		end else begin
			aux_no_o <= 1'b1;
		end
	end
endmodule : hamsc_contactor_model

// ==== testbench/hamsc_supervisor_test.sv ====
// self-checking bench of the motor start supervisor
`timescale 1ns/1ps
module hamsc_supervisor_test import hamsc_pkg::*;;
	// shortened counts; W covers debounce plus the output register
	localparam int D = 4;
	localparam int FBL = 50;
	localparam int W = D + 4;
	localparam logic [4:0] K_START = 5'h01, K_STOP = 5'h02, K_FSTOP = 5'h04;
	localparam logic [4:0] K_RESET = 5'h08, K_FSTART = 5'h10;
	// stimulus, all defined at time zero
	logic sys_clk_i = 1'b0, reset_i = 1'b1, hand = 1'b0, auto = 1'b0, stopc = 1'b0;
	logic maint = 1'b0, pst = 1'b0, ppst = 1'b1, ser = 1'b0, withhold = 1'b0, fb;
	logic [4:0] keys = 5'h00;
	logic [9:0] ilk = 10'h000;
	logic [19:0] ilf = 20'h00000;
	logic contactor_a_o, motor_unavailable_o, trip_latched_o, fb_missing_alarm_o, dropped;
	int n_mismatch = 0, checks = 0, cycles = 0, ia, ib;

	hamsc_supervisor #(.IL_COUNT(10), .DEBOUNCE_CYCLES(D), .FB_LIMIT_CYCLES(FBL)) i_dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sel_hand_i(hand), .sel_auto_i(auto),
		.stop_input_closed_i(stopc), .local_start_pb_i(keys[0]), .local_stop_pb_i(keys[1]),
		.maint_start_i(maint), .auto_pulse_start_contact_i(pst),
		.auto_pulse_stop_contact_i(ppst), .interlock_i(ilk), .contactor_a_fb_i(fb),
		.fp_stop_key_i(keys[2]), .fp_reset_key_i(keys[3]), .fp_start_key_i(keys[4]),
		.serial_start_i(ser), .il_func_i(ilf), .contactor_a_o(contactor_a_o),
		.motor_unavailable_o(motor_unavailable_o), .trip_latched_o(trip_latched_o),
		.fb_missing_alarm_o(fb_missing_alarm_o));

	hamsc_contactor_model i_contactor (
		.sys_clk_i(sys_clk_i), .coil_i(contactor_a_o), .withhold_i(withhold), .aux_no_o(fb));

	// 10 MHz clock
	initial forever #50 sys_clk_i = ~sys_clk_i;

	// hang guard, several times the expected run length
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	task automatic cmp(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// sampled 1 ns after the edge so registered outputs have landed
	task automatic chk(input logic c, input logic t, input logic a);
		#1;
		cmp(contactor_a_o, c);
		cmp(trip_latched_o, t);
		cmp(fb_missing_alarm_o, a);
		cmp(motor_unavailable_o, !stopc);
		@(posedge sys_clk_i);
	endtask : chk
	// keys stay down long enough to pass the debounce, then come up again
	task automatic press(input logic [4:0] m);
		keys <= m;
		cyc(W);
		keys <= 5'h00;
		cyc(W);
	endtask : press

	// watches for the contactor dropping while a stop is held, then drops the start level
	task automatic press_drop(input logic [4:0] m);
		dropped = 1'b0;
		keys <= m;
		repeat (W) begin
			@(posedge sys_clk_i);
			#1;
			if (contactor_a_o === 1'b0) dropped = 1'b1;
		end
		@(posedge sys_clk_i);
		keys <= 5'h00;
		maint <= 1'b0;
		cyc(W);
	endtask : press_drop

	// main sequence
	initial begin
		ia = $urandom(32'h6752);
		cyc(5);
		chk(1'b0, 1'b0, 1'b0);
		cyc(4);
		reset_i <= 1'b0;
		hand <= 1'b1;
		press(K_START);
		chk(1'b0, 1'b0, 1'b0);
		stopc <= 1'b1;
		cyc(W);
		chk(1'b0, 1'b0, 1'b0);
		$display("test stop input done");
		press(K_START);
		chk(1'b1, 1'b0, 1'b0);
		press(K_STOP);
		chk(1'b0, 1'b0, 1'b0);
		press(K_START | K_STOP);
		chk(1'b0, 1'b0, 1'b0);
		$display("test hand done");
		press(K_START);
		hand <= 1'b0;
		cyc(W);
		chk(1'b0, 1'b0, 1'b0);
		ser <= 1'b1;
		press(K_START | K_FSTART);
		ser <= 1'b0;
		chk(1'b0, 1'b0, 1'b0);
		$display("test off done");
		auto <= 1'b1;
		pst <= 1'b1;
		cyc(W);
		pst <= 1'b0;
		cyc(W);
		chk(1'b1, 1'b0, 1'b0);
		ppst <= 1'b0;
		cyc(W);
		ppst <= 1'b1;
		cyc(W);
		chk(1'b0, 1'b0, 1'b0);
		pst <= 1'b1;
		cyc(W);
		chk(1'b1, 1'b0, 1'b0);
		pst <= 1'b0;
		press(K_STOP);
		chk(1'b0, 1'b0, 1'b0);
		$display("test three-wire auto done");
		auto <= 1'b0;
		hand <= 1'b1;
		press(K_START);
		press(K_FSTOP);
		chk(1'b0, 1'b1, 1'b0);
		press(K_START);
		chk(1'b0, 1'b1, 1'b0);
		press(K_RESET);
		chk(1'b0, 1'b0, 1'b0);
		$display("test faceplate stop done");
		withhold <= 1'b1;
		press(K_START);
		cyc(15);
		chk(1'b1, 1'b0, 1'b0);
		cyc(35);
		chk(1'b0, 1'b1, 1'b1);
		withhold <= 1'b0;
		press(K_RESET);
		chk(1'b0, 1'b0, 1'b0);
		$display("test feedback done");
		ia = $urandom % 10;
		ib = (ia + 1 + $urandom % 9) % 10;
		ilf[2*ia +: 2] <= HAMSC_IL_MAINT_RUN;
		hand <= 1'b0;
		auto <= 1'b1;
		maint <= 1'b1;
		cyc(W);
		chk(1'b1, 1'b0, 1'b0);
		press(K_STOP);
		chk(1'b1, 1'b0, 1'b0);
		press(K_FSTOP);
		chk(1'b0, 1'b1, 1'b0);
		press(K_RESET);
		chk(1'b1, 1'b0, 1'b0);
		press(K_FSTOP);
		maint <= 1'b0;
		press(K_RESET);
		chk(1'b0, 1'b0, 1'b0);
		maint <= 1'b1;
		cyc(W);
		chk(1'b1, 1'b0, 1'b0);
		maint <= 1'b0;
		cyc(W);
		chk(1'b0, 1'b0, 1'b0);
		$display("test two-wire auto done");
		ilf[2*ib +: 2] <= HAMSC_IL_AUTO_ENABLE;
		auto <= 1'b0;
		hand <= 1'b1;
		ilk[ib] <= 1'b1;
		maint <= 1'b1;
		cyc(W);
		chk(1'b1, 1'b0, 1'b0);
		maint <= 1'b0;
		cyc(W);
		chk(1'b0, 1'b1, 1'b0);
		press(K_RESET);
		ser <= 1'b1;
		press(K_START | K_FSTART);
		ser <= 1'b0;
		chk(1'b0, 1'b0, 1'b0);
		maint <= 1'b1;
		cyc(W);
		press_drop(K_STOP);
		cmp(dropped, 1'b1);
		chk(1'b0, 1'b1, 1'b0);
		press(K_RESET);
		ilk[ib] <= 1'b0;
		press(K_START);
		chk(1'b1, 1'b0, 1'b0);
		press(K_STOP);
		chk(1'b0, 1'b1, 1'b0);
		press(K_START);
		chk(1'b0, 1'b1, 1'b0);
		$display("test interlock scheme done");
		give_verdict();
	end
endmodule : hamsc_supervisor_test
